// ### rtl/ccsr_pkg.sv
package ccsr_pkg;

  // =====================================================================
  // command codes
  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHARGER_STATUS = 8'h20;
  localparam logic [7:0] CMD_THROTTLE_STATUS = 8'h21;

  // =====================================================================
  // field positions
  localparam int SYSTEM_OVERVOLTAGE_BIT = 4;
  localparam int LATCHOFF_BIT = 2;
  localparam int CUR_LSB = 6;
  localparam int CUR_MSB = 12;
  localparam int CUR_INVALID_LSB = 13;
  localparam int THR_FLAGS = 7;

  // =====================================================================
  // reset values and weights
  localparam logic [15:0] CHARGE_CURRENT_RST = 16'h0000;
  localparam logic [6:0] THROTTLE_RST = 7'h00;
  localparam int CUR_STEP_MA = 64;
  localparam logic [6:0] PRECHARGE_CLAMP_CODE = 7'h06;
  localparam logic [6:0] ONE_CELL_FAST_CLAMP_CODE = 7'h1F;
  localparam logic [6:0] WAKEUP_CURRENT_CODE = 7'h01;

  // =====================================================================
  // throttle trigger bundle
  typedef struct packed {
    logic comparator;
    logic critical_current;
    logic nominal_current;
    logic discharge_current;
    logic system_voltage;
    logic battery_removal;
    logic adapter_removal;
  } ccsr_throttle_t;

  // converter health events
  typedef struct packed {
    logic system_overvoltage;
    logic latch_off;
    logic input_overvoltage;
    logic input_overcurrent;
    logic thermal_shutdown;
  } ccsr_fault_t;

endpackage : ccsr_pkg

// ### rtl/ccsr_regs.sv
// Functional notes
// - current, status and throttle words at command codes 14h, 20h, 21h
// - overvoltage sets status bit 4 and holds the converter off
// - latch clears on host write of 0 or adapter removal, after event
// - latch-off fault bit 2 stays set until host reads status
// - throttle flags bits 6..0 reset to 0, stick at 1 once triggered
// - charge current is seven bits 12..6, 64 mA steps to 8.128 A
// - field bits weighted binary, bit 12 is 4096 mA, bit 6 is 64 mA
// - current write with any of bits 15..13 set is discarded
// - bits 5..0 of current word are ignored on write
// - power-on current is zero unless automatic wakeup is active
// - input-good low clears current, except for input overvoltage
// - battery-present pin low clears current setting
// - current kept through overcurrent, thermal, latch-off, overvoltage
// - battery switch linear mode in pre-charge, control bit default 1
// - multi-cell pre-charge regulates at minimum system, clamps 384 mA
// - single cell pre-charge to fast at 3 V, pre-charge clamp 384 mA
// - single cell 3 V to 3.6 V keeps linear switch, clamps at 1984 mA
// - current write before voltage write starts charging at once
// - zero max-voltage write forces current to zero, stops charge
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port from the smbus engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // charger state inputs
  input wire logic auto_wakeup,
  input wire logic input_good,
  input wire logic adapter_present,
  input wire logic cell_count_battery_present_pin,
  input wire logic single_cell,
  input wire logic in_precharge,
  input wire logic vbat_below_3v,
  input wire logic vbat_below_min_sys,
  input wire logic max_voltage_zero_wr,
  input wire ccsr_pkg::ccsr_fault_t fault_evt,
  input wire ccsr_pkg::ccsr_throttle_t throttle_evt,
  // control outputs
  output logic converter_enable,
  output logic charge_enable,
  output logic battery_switch_linear,
  output logic regulate_min_sys,
  output logic [6:0] applied_current_code
);

  // =====================================================================
  // decode helpers
  function automatic logic cur_wr_valid(input logic [15:0] d);
    cur_wr_valid = (d[15:ccsr_pkg::CUR_INVALID_LSB] == 3'h0);
  endfunction : cur_wr_valid

  function automatic logic [6:0] clamp(input logic [6:0] v,
                                       input logic [6:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  logic [6:0] current_r;
  logic system_overvoltage_r;
  logic latchoff_r;
  ccsr_pkg::ccsr_throttle_t throttle_r;
  logic boot_r;
  logic wr_cur, wr_stat, rd_stat;
  logic adapter_d_r;
  logic adapter_fall;

  always_comb
  begin
    wr_cur = reg_wr && reg_cmd == ccsr_pkg::CMD_CHARGE_CURRENT;
    wr_stat = reg_wr && reg_cmd == ccsr_pkg::CMD_CHARGER_STATUS;
    rd_stat = reg_rd && reg_cmd == ccsr_pkg::CMD_CHARGER_STATUS;
    adapter_fall = adapter_d_r && !adapter_present;
  end

  // =====================================================================
  // charge current setting
  // wakeup value caught on the first clocked cycle after reset, not in it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      current_r <= ccsr_pkg::CHARGE_CURRENT_RST[12:6];
      boot_r <= 1'b1;
    end
    else
    begin
      boot_r <= 1'b0;
      if (!cell_count_battery_present_pin)
        current_r <= 7'h00;
      else if (!input_good && !fault_evt.input_overvoltage)
        current_r <= 7'h00;
      else if (max_voltage_zero_wr)
        current_r <= 7'h00;
      else if (wr_cur && cur_wr_valid(reg_wdata))
        current_r <= reg_wdata[ccsr_pkg::CUR_MSB:ccsr_pkg::CUR_LSB];
      else if (boot_r && auto_wakeup)
        current_r <= ccsr_pkg::WAKEUP_CURRENT_CODE;
      // overcurrent, thermal, latch-off, overvoltage leave it alone
    end
  end

  // =====================================================================
  // system overvoltage latch
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      adapter_d_r <= 1'b0;
    else
      adapter_d_r <= adapter_present;
  end

  // event wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      system_overvoltage_r <= 1'b0;
    else if (fault_evt.system_overvoltage)
      system_overvoltage_r <= 1'b1;
    else if (adapter_fall || (wr_stat && !reg_wdata[ccsr_pkg::SYSTEM_OVERVOLTAGE_BIT]))
      system_overvoltage_r <= 1'b0;
  end

  // latch-off fault, read clears, set wins
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      latchoff_r <= 1'b0;
    else if (fault_evt.latch_off)
      latchoff_r <= 1'b1;
    else if (rd_stat)
      latchoff_r <= 1'b0;
  end

  // throttle flags only ever set; bus writes never reach them
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      throttle_r <= ccsr_pkg::THROTTLE_RST;
    else
      throttle_r <= throttle_r | throttle_evt;
  end

  // =====================================================================
  // read data, registered so the output comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_cmd == ccsr_pkg::CMD_CHARGE_CURRENT)
        reg_rdata <= {3'h0, current_r, 6'h00};
      else if (reg_cmd == ccsr_pkg::CMD_CHARGER_STATUS)
        reg_rdata <= {11'h000, system_overvoltage_r, 1'b0, latchoff_r, 2'h0};
      else if (reg_cmd == ccsr_pkg::CMD_THROTTLE_STATUS)
        reg_rdata <= {9'h000, throttle_r};
      else
        reg_rdata <= 16'h0000;
    end
  end

  // =====================================================================
  // converter control and current clamps
  logic [6:0] clamp_nxt;
  always_comb
  begin
    clamp_nxt = current_r;
    if (in_precharge && (!single_cell || vbat_below_3v))
      clamp_nxt = clamp(current_r, ccsr_pkg::PRECHARGE_CLAMP_CODE);
    else if (single_cell && vbat_below_min_sys)
      clamp_nxt = clamp(current_r, ccsr_pkg::ONE_CELL_FAST_CLAMP_CODE);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      converter_enable <= 1'b0;
      charge_enable <= 1'b0;
      battery_switch_linear <= 1'b1;
      regulate_min_sys <= 1'b0;
      applied_current_code <= 7'h00;
    end
    else
    begin
      converter_enable <= !system_overvoltage_r && !fault_evt.system_overvoltage;
      charge_enable <= current_r != 7'h00;
      battery_switch_linear <= in_precharge ||
                               (single_cell && vbat_below_min_sys);
      regulate_min_sys <= in_precharge && !single_cell;
      applied_current_code <= clamp_nxt;
    end
  end

  // =====================================================================
  // checks
  sequence s_ovp_evt;
    fault_evt.system_overvoltage;
  endsequence

  a_ovp_holds_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ovp_evt |=> system_overvoltage_r ##1 !converter_enable)
    else $error("converter not held off after overvoltage");

  a_ovp_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
    system_overvoltage_r && !adapter_fall && !wr_stat |=> system_overvoltage_r)
    else $error("overvoltage latch dropped without clear");

  a_latchoff_rd: assert property (@(posedge core_clk) disable iff (sys_rst)
    latchoff_r && !rd_stat && !fault_evt.latch_off |=> latchoff_r)
    else $error("latch-off fault lost before read");

  a_throttle_stick: assert property (@(posedge core_clk) disable iff (sys_rst)
    throttle_r.comparator |=> throttle_r.comparator)
    else $error("throttle flag cleared");

  a_bad_wr_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_cur && !cur_wr_valid(reg_wdata) && cell_count_battery_present_pin &&
    input_good && !max_voltage_zero_wr && !boot_r |=> $stable(current_r))
    else $error("invalid current write applied");

  a_good_wr_take: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_cur && cur_wr_valid(reg_wdata) && cell_count_battery_present_pin &&
    input_good && !max_voltage_zero_wr
    |=> current_r == $past(reg_wdata[12:6]))
    else $error("valid current write not applied");

  a_batt_removal: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cell_count_battery_present_pin |=> current_r == 7'h00 ##1 !charge_enable)
    else $error("current not cleared on battery removal");

  a_pre_clamp: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_precharge && !single_cell |=> applied_current_code <= 7'h06)
    else $error("pre-charge current above clamp");

  a_input_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    !input_good && !fault_evt.input_overvoltage |=> current_r == 7'h00)
    else $error("current not cleared on input loss");

  // =====================================================================
  // checks on power-up, keep and clear paths of the current setting
  // wakeup code lands on the first cycle out of reset only
  a_wake_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    boot_r && auto_wakeup && cell_count_battery_present_pin && input_good &&
    !max_voltage_zero_wr && !wr_cur
    |=> current_r == ccsr_pkg::WAKEUP_CURRENT_CODE)
    else $error("wakeup current not loaded");

  // setting is zero as reset leaves
  a_boot_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    boot_r && !auto_wakeup |-> current_r == 7'h00)
    else $error("current not zero after reset");

  // zero max-voltage write wipes the setting
  a_maxv_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    max_voltage_zero_wr |=> current_r == 7'h00)
    else $error("current not cleared by max-voltage zero");

  // faults alone never touch the setting
  a_keep_faults: assert property (@(posedge core_clk) disable iff (sys_rst)
    cell_count_battery_present_pin && input_good && !max_voltage_zero_wr &&
    !wr_cur && !boot_r |=> $stable(current_r))
    else $error("current changed by a fault");

  // input overvoltage is the one input-loss case that keeps the value
  a_inov_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    !input_good && fault_evt.input_overvoltage &&
    cell_count_battery_present_pin && !max_voltage_zero_wr && !wr_cur &&
    !boot_r |=> $stable(current_r))
    else $error("current changed on input overvoltage");

  // charging starts as soon as a nonzero setting stands
  a_chg_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    current_r != 7'h00 |=> charge_enable)
    else $error("charge not enabled with nonzero current");

  // zero setting means no charge
  a_chg_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    current_r == 7'h00 |=> !charge_enable)
    else $error("charge enabled with zero current");

  // =====================================================================
  // checks on the status latches
  // converter returns once the latch is gone and no event stands
  a_conv_back: assert property (@(posedge core_clk) disable iff (sys_rst)
    !system_overvoltage_r && !fault_evt.system_overvoltage |=> converter_enable)
    else $error("converter not re-enabled");

  // a written zero clears the latch when no new event arrives
  a_ovp_wr_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
    system_overvoltage_r && wr_stat && !reg_wdata[ccsr_pkg::SYSTEM_OVERVOLTAGE_BIT] &&
    !fault_evt.system_overvoltage |=> !system_overvoltage_r)
    else $error("overvoltage latch not cleared by write");

  // a status read clears the latch-off fault
  a_latchoff_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_stat && !fault_evt.latch_off |=> !latchoff_r)
    else $error("latch-off fault not cleared by read");

  // no throttle flag ever falls once set
  a_thr_all: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> ((throttle_r & $past(throttle_r)) == $past(throttle_r)))
    else $error("throttle flag dropped");

  // a battery-removal trigger pulse sets its flag
  a_thr_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    throttle_evt.battery_removal |=> throttle_r.battery_removal)
    else $error("throttle flag not set");

  // =====================================================================
  // checks on read data format
  // status word shows nothing in its reserved bits
  a_stat_rsvd: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_cmd == ccsr_pkg::CMD_CHARGER_STATUS
    |=> reg_rdata[15:5] == 11'h000 && !reg_rdata[3] && reg_rdata[1:0] == 2'h0)
    else $error("status reserved bits set");

  // throttle word upper bits stay clear
  a_thr_rsvd: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_cmd == ccsr_pkg::CMD_THROTTLE_STATUS
    |=> reg_rdata[15:7] == 9'h000)
    else $error("throttle reserved bits set");

  // current field sits at bits 12..6, the rest reads zero
  a_cur_fmt: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_cmd == ccsr_pkg::CMD_CHARGE_CURRENT
    |=> reg_rdata[15:13] == 3'h0 && reg_rdata[5:0] == 6'h00 &&
    reg_rdata[12:6] == $past(current_r))
    else $error("current word badly formatted");

  // =====================================================================
  // checks on the clamps and the switch mode
  // single cell below 3 V keeps the pre-charge clamp
  a_one_pre: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_precharge && single_cell && vbat_below_3v
    |=> applied_current_code <= ccsr_pkg::PRECHARGE_CLAMP_CODE)
    else $error("single cell pre-charge above clamp");

  // single cell between 3 V and minimum system, fast charge capped
  a_one_fast: assert property (@(posedge core_clk) disable iff (sys_rst)
    !in_precharge && single_cell && vbat_below_min_sys
    |=> applied_current_code <= ccsr_pkg::ONE_CELL_FAST_CLAMP_CODE &&
    battery_switch_linear)
    else $error("single cell fast charge above clamp");

  // multi-cell pre-charge holds the system at its minimum
  a_min_sys: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_precharge && !single_cell |=> regulate_min_sys)
    else $error("minimum system regulation missing");

  // pre-charge always runs the switch linear
  a_lin_pre: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_precharge |=> battery_switch_linear)
    else $error("switch not linear in pre-charge");

endmodule : ccsr_regs

`default_nettype wire

// ### verif/ccsr_host.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// host model: one-cycle register requests, launched just after an edge
module ccsr_host
(
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_cmd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // park on an unmapped code so a stale command never hits a register
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'hFF;
    reg_wdata = 16'h0000;
  end

  // released data shows the inverse, never the last value
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_cmd = c;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_cmd = 8'hFF;
    reg_wdata = ~d;
  endtask : wr

  // read data is taken at the edge after the request
  task rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_cmd = c;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_cmd = 8'hFF;
    d = reg_rdata;
  endtask : rd
endmodule : ccsr_host

`default_nettype wire

// ### verif/tb_charger_status_and_current_setting.sv
`timescale 1ns/1ps
`default_nettype none

module tb_charger_status_and_current_setting;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, auto_wakeup = 1'b0, input_good = 1'b1;
  logic adapter_present = 1'b1, cell_count_battery_present_pin = 1'b1;
  logic single_cell = 1'b0, in_precharge = 1'b0, vbat_below_3v = 1'b0;
  logic vbat_below_min_sys = 1'b0, max_voltage_zero_wr = 1'b0;
  logic converter_enable, charge_enable, battery_switch_linear;
  logic regulate_min_sys;
  logic [6:0] applied_current_code;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata, d;
  ccsr_pkg::ccsr_fault_t fault_evt = '0;
  ccsr_pkg::ccsr_throttle_t throttle_evt = '0;
  int error_cnt = 0;
  int checks_done = 0;

  // =====================================================================
  // design and host
  ccsr_regs ccsr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .auto_wakeup(auto_wakeup), .input_good(input_good),
    .adapter_present(adapter_present),
    .cell_count_battery_present_pin(cell_count_battery_present_pin),
    .single_cell(single_cell), .in_precharge(in_precharge),
    .vbat_below_3v(vbat_below_3v), .vbat_below_min_sys(vbat_below_min_sys),
    .max_voltage_zero_wr(max_voltage_zero_wr), .fault_evt(fault_evt),
    .throttle_evt(throttle_evt), .converter_enable(converter_enable),
    .charge_enable(charge_enable),
    .battery_switch_linear(battery_switch_linear),
    .regulate_min_sys(regulate_min_sys),
    .applied_current_code(applied_current_code));
  ccsr_host ccsr_host_i (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // =====================================================================
  // helpers
  task check(input string n, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task rd_chk(input logic [7:0] c, input logic [15:0] e);
    ccsr_host_i.rd(c, d);
    check("read word", d, e);
  endtask : rd_chk

  task do_reset(input logic wake);
    sys_rst = 1'b1;
    auto_wakeup = wake;
    tick(20);
    check("linear rst", 16'(battery_switch_linear), 16'h0001);
    sys_rst = 1'b0;
    tick(2);
    auto_wakeup = 1'b0;
  endtask : do_reset

  // =====================================================================
  // scenarios
  task t_reset;
    check("linear idle", 16'(battery_switch_linear), 16'h0000);
    rd_chk(8'h14, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    rd_chk(8'h21, 16'h0000);
    rd_chk(8'h33, 16'h0000);
    do_reset(1'b1);
    rd_chk(8'h14, 16'h0040);
    $display("test reset done");
  endtask : t_reset

  task t_current;
    ccsr_host_i.wr(8'h14, 16'h1FFF);
    tick(3);
    rd_chk(8'h14, 16'h1FC0);
    check("code", 16'(applied_current_code), 16'h007F);
    check("chg en", 16'(charge_enable), 16'h0001);
    for (int k = 13; k < 16; k++)
    begin
      ccsr_host_i.wr(8'h14, 16'h0040 | (16'h0001 << k));
      rd_chk(8'h14, 16'h1FC0);
    end
    ccsr_host_i.wr(8'h14, 16'h1000);
    tick(3);
    check("code", 16'(applied_current_code), 16'h0040);
    ccsr_host_i.wr(8'h14, 16'h0000);
    tick(3);
    check("chg en", 16'(charge_enable), 16'h0000);
    $display("test current done");
  endtask : t_current

  // each loss condition must wipe the setting; the overvoltage one not
  task t_clear;
    for (int k = 0; k < 5; k++)
    begin
      ccsr_host_i.wr(8'h14, 16'h0FC0);
      input_good = (k == 0 || k == 3) ? 1'b0 : 1'b1;
      cell_count_battery_present_pin = (k != 1);
      max_voltage_zero_wr = (k == 2);
      fault_evt = (k == 3) ? 5'h04 : (k == 4) ? 5'h1B : 5'h00;
      tick(1);
      max_voltage_zero_wr = 1'b0;
      tick(1);
      input_good = 1'b1;
      cell_count_battery_present_pin = 1'b1;
      fault_evt = '0;
      rd_chk(8'h14, (k > 2) ? 16'h0FC0 : 16'h0000);
    end
    $display("test clear done");
  endtask : t_clear

  task t_status;
    do_reset(1'b0);
    fault_evt.system_overvoltage = 1'b1;
    tick(2);
    fault_evt.system_overvoltage = 1'b0;
    tick(2);
    check("conv en", 16'(converter_enable), 16'h0000);
    rd_chk(8'h20, 16'h0010);
    ccsr_host_i.wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, 16'h0010);
    ccsr_host_i.wr(8'h20, 16'h0000);
    tick(2);
    check("conv en", 16'(converter_enable), 16'h0001);
    fault_evt.system_overvoltage = 1'b1;
    tick(1);
    fault_evt.system_overvoltage = 1'b0;
    adapter_present = 1'b0;
    tick(2);
    adapter_present = 1'b1;
    rd_chk(8'h20, 16'h0000);
    fault_evt.latch_off = 1'b1;
    tick(1);
    fault_evt.latch_off = 1'b0;
    rd_chk(8'h20, 16'h0004);
    rd_chk(8'h20, 16'h0000);
    $display("test status done");
  endtask : t_status

  task t_throttle;
    logic [15:0] e;
    e = 16'h0000;
    for (int i = 0; i < 7; i++)
    begin
      throttle_evt = 7'(1 << i);
      tick(1);
      throttle_evt = '0;
      e = e | 16'(1 << i);
      rd_chk(8'h21, e);
    end
    ccsr_host_i.wr(8'h21, 16'h0000);
    rd_chk(8'h21, 16'h007F);
    $display("test throttle done");
  endtask : t_throttle

  task t_clamp;
    ccsr_host_i.wr(8'h14, 16'h1FC0);
    in_precharge = 1'b1;
    tick(3);
    check("code", 16'(applied_current_code), 16'h0006);
    check("min sys", 16'(regulate_min_sys), 16'h0001);
    check("linear", 16'(battery_switch_linear), 16'h0001);
    single_cell = 1'b1;
    vbat_below_3v = 1'b1;
    vbat_below_min_sys = 1'b1;
    tick(3);
    check("code", 16'(applied_current_code), 16'h0006);
    in_precharge = 1'b0;
    vbat_below_3v = 1'b0;
    tick(3);
    check("code", 16'(applied_current_code), 16'h001F);
    check("linear", 16'(battery_switch_linear), 16'h0001);
    vbat_below_min_sys = 1'b0;
    tick(3);
    check("code", 16'(applied_current_code), 16'h007F);
    rd_chk(8'h14, 16'h1FC0);
    $display("test clamp done");
  endtask : t_clamp

  // =====================================================================
  // verdict, reached from the sequence or the watchdog
  task summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    do_reset(1'b0);
    t_reset();
    t_current();
    t_clear();
    t_status();
    t_throttle();
    t_clamp();
    summarize();
  end
endmodule : tb_charger_status_and_current_setting

`default_nettype wire
